// *** inc/usb_ctrl_pkg.sv ***
// Purpose: shared constants and carriers for the usb control/status register block
// Assumes: 32-bit classic wishbone, one 16-bit register per aligned word
// Notes:   offsets are byte addresses
package usb_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] OFF_ERROR_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_ERROR_EN     = 8'h08;
  localparam logic [7:0] OFF_PWM_CONTROL  = 8'h0C;
  localparam logic [7:0] OFF_MODE         = 8'h10;
  localparam logic [7:0] OFF_IRQ_FLAGS    = 8'h14;
  localparam logic [7:0] OFF_EP_BASE      = 8'h40;
  localparam int         NUM_EP           = 16;

  // ----------------------------------------------------------------
  // interrupt enable / status field positions
  // ----------------------------------------------------------------
  localparam int BIT_STALL      = 7;
  localparam int BIT_ATTACH     = 6;
  localparam int BIT_RESUME     = 5;
  localparam int BIT_IDLE       = 4;
  localparam int BIT_TOKEN_DONE = 3;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_ERR_SUMMARY = 1;
  localparam int BIT_RESET_DETACH = 0;

  // ----------------------------------------------------------------
  // error flag / enable field positions
  // ----------------------------------------------------------------
  localparam int BIT_BIT_STUFF   = 7;
  localparam int BIT_BUF_OVERRUN = 5;
  localparam int BIT_TURNAROUND  = 4;
  localparam int BIT_PARTIAL     = 3;
  localparam int BIT_DATA_CRC    = 2;
  localparam int BIT_TOKEN_EOF   = 1;
  localparam int BIT_PACKET_ID   = 0;
  localparam logic [7:0] ERR_IMPL_MASK = 8'hBF;

  // ----------------------------------------------------------------
  // endpoint field positions
  // ----------------------------------------------------------------
  localparam int BIT_LOW_SPEED   = 7;
  localparam int BIT_NAK_RETRY   = 6;
  localparam int BIT_CTRL_DIS    = 4;
  localparam int BIT_RX_EN       = 3;
  localparam int BIT_TX_EN       = 2;
  localparam int BIT_STALLED     = 1;
  localparam int BIT_HANDSHAKE   = 0;
  localparam logic [7:0] EP_IMPL_MASK  = 8'h1F;

  // ----------------------------------------------------------------
  // pwm control field positions
  // ----------------------------------------------------------------
  localparam int BIT_PWM_EN      = 15;
  localparam int BIT_PWM_POL     = 9;
  localparam int BIT_PWM_CNT_EN  = 8;
  localparam logic [15:0] PWM_IMPL_MASK = 16'h8300;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // error events reported by the serial engine, one cycle pulses
  typedef struct packed {
    logic bit_stuff;
    logic buf_overrun;
    logic turnaround;
    logic partial_byte;
    logic data_crc;
    logic token_crc;
    logic frame_end;
    logic packet_id;
  } err_evt_t;

  // usb events reported by the serial engine, one cycle pulses
  typedef struct packed {
    logic stall;
    logic attach;
    logic resume;
    logic idle;
    logic token_done;
    logic frame_start;
    logic bus_reset;
    logic detach;
  } usb_evt_t;

  // per-endpoint decoded controls
  typedef struct packed {
    logic rx_allow;
    logic tx_allow;
    logic setup_allow;
    logic stalled;
    logic handshake;
  } ep_ctrl_t;

endpackage : usb_ctrl_pkg

// *** rtl/usb_irq_error_endpoint_ctrl.sv ***
// Purpose: usb interrupt enables, error flags, endpoint control and power pwm control
// Assumes: classic wishbone slave, events from the serial engine are single-cycle pulses
// Notes:   ack one cycle after the request is seen; unmapped words read zero and ignore writes
`timescale 1ns/100ps

// Operation
// - interrupt enable bits stall 7, resume 5, idle 4, token 3, sof 2, error 1.
// - attach enable bit 6 exists only in host mode, reads zero in device mode.
// - enable bit 0 gates bus reset in device mode, detach in host mode.
// - upper byte of each register except pwm control reads zero.
// - bit stuff error sets flag bit 7, held until software clears it.
// - buffer overrun sets flag bit 5 and received data is truncated.
// - turnaround timeout sets flag bit 4.
// - non-whole-byte data field sets flag bit 3.
// - data crc failure sets bit 2, packet id failure sets bit 0.
// - device mode token crc error sets flag bit 1.
// - host mode end-of-frame error sets flag bit 1 instead.
// - writing one clears an error flag, zero leaves it; use full-word writes.
// - error enable register mirrors flag positions; bit 1 follows the mode.
// - sixteen independent endpoint control registers, index zero to fifteen.
// - low speed and retry disable exist only on endpoint zero in host mode.
// - low speed direct bit steers host toward a directly attached slow device.
// - retry disable clear allows automatic nak retry, set forbids it.
// - with tx and rx enabled, bit 4 forbids setup; otherwise ignored.
// - endpoint bit 3 enables receive, bit 2 transmit; clear refuses that direction.
// - bit 1 shows stall, bit 0 enables handshakes, clear suppresses them.
// - pwm enable clear holds the output at the polarity-selected idle level.
// - polarity set gives active-low idle high; bit 8 enables the counter.
// - error summary flag is set only by enabled error flags.
// - clearing token complete advances the transfer status fifo.
module usb_irq_error_endpoint_ctrl
  import usb_ctrl_pkg::*;
#(
  parameter int EP_COUNT = NUM_EP
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  input  wire logic                  wb_we_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic                       wb_ack_o,
  input  wire err_evt_t              err_evt,
  input  wire usb_evt_t              usb_evt,
  input  wire logic [3:0]            ep_sel,
  input  wire logic                  rx_bytes_over,
  output ep_ctrl_t                   ep_ctrl,
  output logic                       rx_truncate,
  output logic                       low_speed_direct,
  output logic                       nak_retry_en,
  output logic                       host_mode,
  output logic                       stat_fifo_advance,
  output logic                       power_gen_enable,
  output logic                       power_gen_counter_enable,
  output logic                       power_gen_idle_level,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        ack_r;
  logic        req;
  logic        wr_lo;
  logic        wr_hi;
  logic        hit_ep;
  logic [3:0]  ep_idx;
  logic [7:0]  wbyte;

  assign req     = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_lo   = req && wb_we_i && wb_sel_i[0];
  assign wr_hi   = req && wb_we_i && wb_sel_i[1];
  assign wbyte   = wb_dat_i[7:0];
  assign hit_ep  = (wb_adr_i[7:6] == OFF_EP_BASE[7:6]) && (wb_adr_i[1:0] == 2'b00);
  assign ep_idx  = wb_adr_i[5:2];

  function automatic logic hit(input logic [7:0] off, input logic [7:0] adr);
    return adr == off;
  endfunction : hit

  // one select per register, shared by the write strobes and the read mux
  logic        sel_irq_en;
  logic        sel_err_flags;
  logic        sel_err_en;
  logic        sel_pwm;
  logic        sel_mode;
  logic        sel_irq_flags;

  assign sel_irq_en    = hit(OFF_IRQ_ENABLE, wb_adr_i);
  assign sel_err_flags = hit(OFF_ERROR_FLAGS, wb_adr_i);
  assign sel_err_en    = hit(OFF_ERROR_EN, wb_adr_i);
  assign sel_pwm       = hit(OFF_PWM_CONTROL, wb_adr_i);
  assign sel_mode      = hit(OFF_MODE, wb_adr_i);
  assign sel_irq_flags = hit(OFF_IRQ_FLAGS, wb_adr_i);

  // a write is taken once, in the cycle before ack; only the pwm word uses lane 1
  logic        wr_irq_en;
  logic        wr_err_flags;
  logic        wr_err_en;
  logic        wr_pwm;
  logic        wr_mode;
  logic        wr_irq_flags;

  assign wr_irq_en    = wr_lo && sel_irq_en;
  assign wr_err_flags = wr_lo && sel_err_flags;
  assign wr_err_en    = wr_lo && sel_err_en;
  assign wr_pwm       = (wr_lo || wr_hi) && sel_pwm;
  assign wr_mode      = wr_lo && sel_mode;
  assign wr_irq_flags = wr_lo && sel_irq_flags;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  irq_en_r;
  logic [7:0]  irq_en_nxt;
  logic [7:0]  err_flags_r;
  logic [7:0]  err_flags_nxt;
  logic [7:0]  err_en_r;
  logic [7:0]  err_en_nxt;
  logic [15:0] pwm_ctl_r;
  logic [15:0] pwm_ctl_nxt;
  logic        host_mode_r;
  logic [7:0]  usb_flags_r;
  logic [7:0]  usb_flags_nxt;
  logic [7:0]  ep_r [EP_COUNT];
  logic        fifo_adv_r;

  // ----------------------------------------------------------------
  // interrupt enables
  // ----------------------------------------------------------------
  logic [7:0] irq_en_mask;
  logic [7:0] irq_en_view;
  // attach enable is absent in device mode
  assign irq_en_mask = host_mode_r ? 8'hFF : 8'hBF;
  assign irq_en_nxt  = wr_irq_en ? (wbyte & irq_en_mask) : (irq_en_r & irq_en_mask);
  // the stored bit lingers one cycle after a switch to device mode, so mask it here too
  assign irq_en_view = irq_en_r & irq_en_mask;

  // ----------------------------------------------------------------
  // error flags
  // ----------------------------------------------------------------
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic       mode_bit1_evt;

  // bit 1 is the token crc in device mode, frame end in host mode
  assign mode_bit1_evt = host_mode_r ? err_evt.frame_end : err_evt.token_crc;
  assign err_set = {err_evt.bit_stuff, 1'b0, err_evt.buf_overrun, err_evt.turnaround,
                    err_evt.partial_byte, err_evt.data_crc,
                    mode_bit1_evt, err_evt.packet_id};
  // write one clears; a set in the same cycle wins
  assign err_clr = wr_err_flags ? wbyte : 8'h00;
  assign err_flags_nxt = ((err_flags_r & ~err_clr) | err_set) & ERR_IMPL_MASK;

  assign err_en_nxt = wr_err_en ? (wbyte & ERR_IMPL_MASK) : err_en_r;

  // ----------------------------------------------------------------
  // usb interrupt status (summary and token fifo hook)
  // ----------------------------------------------------------------
  logic [7:0] usb_set;
  logic [7:0] usb_clr;
  logic       err_summary;

  assign err_summary = |(err_flags_r & err_en_r);
  assign usb_set = {usb_evt.stall, usb_evt.attach & host_mode_r, usb_evt.resume,
                    usb_evt.idle, usb_evt.token_done, usb_evt.frame_start, 1'b0,
                    host_mode_r ? usb_evt.detach : usb_evt.bus_reset};
  assign usb_clr = wr_irq_flags ? wbyte : 8'h00;
  assign usb_flags_nxt = (usb_flags_r & ~usb_clr) | usb_set;

  // ----------------------------------------------------------------
  // pwm control
  // ----------------------------------------------------------------
  logic [15:0] pwm_wmask;
  assign pwm_wmask   = PWM_IMPL_MASK & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign pwm_ctl_nxt = wr_pwm ?
                       ((pwm_ctl_r & ~pwm_wmask) | (wb_dat_i[15:0] & pwm_wmask)) :
                       pwm_ctl_r;

  // ----------------------------------------------------------------
  // clocked state
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ack_r       <= 1'b0;
      irq_en_r    <= RST_BYTE;
      err_flags_r <= RST_BYTE;
      err_en_r    <= RST_BYTE;
      pwm_ctl_r   <= RST_WORD;
      host_mode_r <= 1'b0;
      usb_flags_r <= RST_BYTE;
      fifo_adv_r  <= 1'b0;
    end else begin
      ack_r       <= req;
      irq_en_r    <= irq_en_nxt;
      err_flags_r <= err_flags_nxt;
      err_en_r    <= err_en_nxt;
      pwm_ctl_r   <= pwm_ctl_nxt;
      usb_flags_r <= usb_flags_nxt;
      fifo_adv_r  <= usb_clr[BIT_TOKEN_DONE] && usb_flags_r[BIT_TOKEN_DONE];
      if (wr_mode) begin
        host_mode_r <= wbyte[0];
      end
    end
  end

  // endpoint registers: endpoint zero keeps the host-only bits
  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g++) begin : g_ep
      localparam logic [7:0] EP_MASK = (g == 0) ? 8'hDF : EP_IMPL_MASK;
      logic ep_wr;
      assign ep_wr = wr_lo && hit_ep && (ep_idx == 4'(g));
      always_ff @(posedge clock) begin
        if (!nrst) begin
          ep_r[g] <= RST_BYTE;
        end else if (ep_wr) begin
          ep_r[g] <= wbyte & EP_MASK;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] ep_view;
  logic [7:0] ep_rd;
  logic [7:0] usb_view;

  function automatic logic [7:0] ep_visible(input logic [7:0] v, input logic [3:0] i,
                                            input logic host);
    return (i == 4'h0 && host) ? v : (v & EP_IMPL_MASK);
  endfunction : ep_visible

  assign ep_rd    = ep_visible(ep_r[ep_idx], ep_idx, host_mode_r);
  assign ep_view  = ep_visible(ep_r[ep_sel], ep_sel, host_mode_r);
  assign usb_view = {usb_flags_r[7:2], err_summary, usb_flags_r[0]};

  always_comb begin
    wb_dat_o = RD_UNMAPPED;
    if (ack_r && !wb_we_i) begin
      if (sel_irq_en) begin
        wb_dat_o = {24'h00_0000, irq_en_view};
      end else if (sel_err_flags) begin
        wb_dat_o = {24'h00_0000, err_flags_r};
      end else if (sel_err_en) begin
        wb_dat_o = {24'h00_0000, err_en_r};
      end else if (sel_pwm) begin
        wb_dat_o = {16'h0000, pwm_ctl_r};
      end else if (sel_mode) begin
        wb_dat_o = {31'h0000_0000, host_mode_r};
      end else if (sel_irq_flags) begin
        wb_dat_o = {24'h00_0000, usb_view};
      end else if (hit_ep) begin
        wb_dat_o = {24'h00_0000, ep_rd};
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs to the engine
  // ----------------------------------------------------------------
  logic both_dirs;
  assign both_dirs = ep_view[BIT_RX_EN] && ep_view[BIT_TX_EN];

  assign wb_ack_o             = ack_r;
  assign ep_ctrl.rx_allow     = ep_view[BIT_RX_EN];
  assign ep_ctrl.tx_allow     = ep_view[BIT_TX_EN];
  assign ep_ctrl.setup_allow  = both_dirs && !ep_view[BIT_CTRL_DIS];
  assign ep_ctrl.stalled      = ep_view[BIT_STALLED];
  assign ep_ctrl.handshake    = ep_view[BIT_HANDSHAKE];
  assign rx_truncate          = rx_bytes_over;
  assign low_speed_direct     = host_mode_r && ep_r[0][BIT_LOW_SPEED];
  assign nak_retry_en         = !(host_mode_r && ep_r[0][BIT_NAK_RETRY]);
  assign host_mode            = host_mode_r;
  assign stat_fifo_advance    = fifo_adv_r;
  assign power_gen_enable     = pwm_ctl_r[BIT_PWM_EN];
  assign power_gen_counter_enable = pwm_ctl_r[BIT_PWM_CNT_EN];
  assign power_gen_idle_level = pwm_ctl_r[BIT_PWM_POL];
  assign irq = |(usb_view & irq_en_view);

endmodule : usb_irq_error_endpoint_ctrl

// *** tb/usb_ctrl_assertions.sv ***
// Purpose: protocol and field checks on the usb control block ports
// Assumes: aligned word accesses, master holds address until ack
// Notes:   bound into every instance of the block
`timescale 1ns/100ps
module usb_ctrl_assertions
  import usb_ctrl_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        rx_bytes_over,
  input wire logic        rx_truncate,
  input wire logic        low_speed_direct,
  input wire logic        nak_retry_en,
  input wire logic        host_mode,
  input wire logic        stat_fifo_advance,
  input wire logic        power_gen_enable,
  input wire logic        power_gen_counter_enable,
  input wire logic        power_gen_idle_level
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire ep_rd  = rd_ack && wb_adr_i >= OFF_EP_BASE && wb_adr_i < 8'h80;
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  upper_byte_a: assert property (rd_ack && wb_adr_i != OFF_PWM_CONTROL |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper byte not zero");
  attach_dev_a: assert property (rd_ack && wb_adr_i == OFF_IRQ_ENABLE && !host_mode |-> !wb_dat_o[6])
    else $error("attach enable seen in device mode");
  err_gap_a: assert property (rd_ack && (wb_adr_i == OFF_ERROR_FLAGS || wb_adr_i == OFF_ERROR_EN) |-> !wb_dat_o[6])
    else $error("error bit 6 not zero");
  ep_upper_a: assert property (ep_rd |-> !wb_dat_o[5] && (wb_adr_i == OFF_EP_BASE && host_mode || wb_dat_o[7:6] == 2'h0))
    else $error("endpoint host bits visible");
  pwm_fields_a: assert property (rd_ack && wb_adr_i == OFF_PWM_CONTROL |-> (wb_dat_o & ~32'h0000_8300) == 32'h0 && wb_dat_o[15] == power_gen_enable && wb_dat_o[9] == power_gen_idle_level && wb_dat_o[8] == power_gen_counter_enable)
    else $error("pwm fields disagree");
  trunc_follow_a: assert property (rx_truncate == rx_bytes_over)
    else $error("truncate not following overrun");
  ep0_host_a: assert property (low_speed_direct || !nak_retry_en |-> host_mode)
    else $error("host endpoint bits active in device mode");
  adv_pulse_a: assert property (stat_fifo_advance |=> !stat_fifo_advance)
    else $error("fifo advance longer than one cycle");
endmodule : usb_ctrl_assertions

bind usb_irq_error_endpoint_ctrl usb_ctrl_assertions u_usb_ctrl_assertions (
  .clock(clock), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .rx_bytes_over(rx_bytes_over), .rx_truncate(rx_truncate),
  .low_speed_direct(low_speed_direct), .nak_retry_en(nak_retry_en), .host_mode(host_mode),
  .stat_fifo_advance(stat_fifo_advance), .power_gen_enable(power_gen_enable),
  .power_gen_counter_enable(power_gen_counter_enable),
  .power_gen_idle_level(power_gen_idle_level)
);

// *** tb/usb_evt_model.sv ***
// Purpose: far-side bus partner producing error and usb event pulses
// Assumes: bench raises an error or usb event request for exactly one cycle
// Notes:   events are registered so they leave just after a clock edge
`timescale 1ns/100ps
module usb_evt_model
  import usb_ctrl_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     nrst,
  input  wire err_evt_t err_req,
  input  wire usb_evt_t usb_req,
  input  wire logic     over_req,
  output err_evt_t      err_evt,
  output usb_evt_t      usb_evt,
  output logic          rx_bytes_over
);
  // ----------------------------------------------------------------
  // event pulses, quiet during reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    err_evt       <= nrst ? err_req : '0;
    usb_evt       <= nrst ? usb_req : '0;
    rx_bytes_over <= nrst && over_req;
  end
endmodule : usb_evt_model

// *** tb/tb.sv ***
// Purpose: self-checking bench for the usb control/status block
// Assumes: one-cycle ack, events visible one cycle after their pulse
// Notes:   read data is taken at the rising edge that samples ack high
`timescale 1ns/100ps
module tb
  import usb_ctrl_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        clock, nrst, cyc, stb, we, over_req, ack, rx_bytes_over, trunc, lsd, nak, host;
  logic        adv, pen, pcnt, pidle, irq;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, q;
  logic [3:0]  sel, ep_sel;
  ep_ctrl_t    ep_ctrl;
  err_evt_t    err_req, err_evt;
  usb_evt_t    usb_req, usb_evt;
  int          error_cnt, num_checks, cycles, adv_cnt;
  localparam logic [63:0] DEV_MAP  = 64'h8020_1008_0402_0001;
  localparam logic [63:0] HOST_MAP = 64'h8020_1008_0400_0201;
  usb_irq_error_endpoint_ctrl #(.EP_COUNT(NUM_EP)) u_usb_irq_error_endpoint_ctrl (
    .clock(clock), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .err_evt(err_evt), .usb_evt(usb_evt), .ep_sel(ep_sel), .rx_bytes_over(rx_bytes_over),
    .ep_ctrl(ep_ctrl), .rx_truncate(trunc), .low_speed_direct(lsd), .nak_retry_en(nak),
    .host_mode(host), .stat_fifo_advance(adv), .power_gen_enable(pen),
    .power_gen_counter_enable(pcnt), .power_gen_idle_level(pidle), .irq(irq));
  usb_evt_model u_usb_evt_model (.clock(clock), .nrst(nrst), .err_req(err_req),
    .usb_req(usb_req), .over_req(over_req), .err_evt(err_evt), .usb_evt(usb_evt),
    .rx_bytes_over(rx_bytes_over));
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (adv === 1'b1) adv_cnt++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, 4'h3};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    chk({31'h0, ack}, 32'h1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 32'h0, 1'b0);
    chk(q, exp);
  endtask : rd
  task automatic fire(input logic [7:0] e, input logic [7:0] u);
    @(posedge clock);
    {err_req, usb_req} <= {e, u};
    @(posedge clock);
    {err_req, usb_req} <= 16'h0000;
    repeat (2) @(posedge clock);
  endtask : fire
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_IRQ_ENABLE, 32'h0);
    rd(OFF_ERROR_FLAGS, 32'h0);
    rd(OFF_ERROR_EN, 32'h0);
    rd(OFF_PWM_CONTROL, 32'h0);
    rd(OFF_EP_BASE, 32'h0);
    chk({29'h0, nak, pidle, irq}, 32'h4);
  endtask : t_reset
  task automatic t_usb_irq();
    wr(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd(OFF_IRQ_ENABLE, 32'hBF);
    wr(OFF_MODE, 32'h1);
    wr(OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd(OFF_IRQ_ENABLE, 32'hFF);
    for (int i = 2; i < 8; i++) begin
      fire(8'h00, 8'h01 << i);
      rd(OFF_IRQ_FLAGS, 32'h1 << i);
      chk({31'h0, irq}, 32'h1);
      wr(OFF_IRQ_FLAGS, 32'hFF);
      chk({31'h0, irq}, 32'h0);
    end
    wr(OFF_IRQ_ENABLE, 32'h1);
    fire(8'h00, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_FLAGS, 32'hFF);
    wr(OFF_MODE, 32'h0);
    rd(OFF_IRQ_ENABLE, 32'h1);
    fire(8'h00, 8'h02);
    rd(OFF_IRQ_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_FLAGS, 32'hFF);
    wr(OFF_IRQ_ENABLE, 32'h0);
  endtask : t_usb_irq
  task automatic t_errors(input logic mode);
    wr(OFF_MODE, {31'h0, mode});
    for (int i = 0; i < 8; i++) begin
      fire(8'h01 << i, 8'h00);
      rd(OFF_ERROR_FLAGS, mode ? HOST_MAP[8*i +: 8] : DEV_MAP[8*i +: 8]);
      wr(OFF_ERROR_FLAGS, 32'hFF);
      rd(OFF_ERROR_FLAGS, 32'h0);
    end
  endtask : t_errors
  task automatic t_summary();
    wr(OFF_ERROR_EN, 32'hFFFF_FFFF);
    rd(OFF_ERROR_EN, 32'hBF);
    wr(OFF_ERROR_EN, 32'h4);
    wr(OFF_IRQ_ENABLE, 32'h2);
    fire(8'h10, 8'h00);
    rd(OFF_IRQ_FLAGS, 32'h0);
    fire(8'h08, 8'h00);
    rd(OFF_IRQ_FLAGS, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_ERROR_FLAGS, 32'h4);
    rd(OFF_ERROR_FLAGS, 32'h8);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_ERROR_FLAGS, 32'h8);
    rd(OFF_ERROR_FLAGS, 32'h0);
  endtask : t_summary
  task automatic t_endpoints();
    wr(OFF_MODE, 32'h0);
    chk({31'h0, host}, 32'h0);
    for (int n = 0; n < NUM_EP; n++) wr(OFF_EP_BASE + 8'(4 * n), 32'hFFF0 | n);
    for (int n = 0; n < NUM_EP; n++) rd(OFF_EP_BASE + 8'(4 * n), 32'h10 | n);
    wr(OFF_MODE, 32'h1);
    rd(OFF_MODE, 32'h1);
    chk({31'h0, host}, 32'h1);
    wr(OFF_EP_BASE, 32'hC0);
    rd(OFF_EP_BASE, 32'hC0);
    chk({30'h0, lsd, nak}, 32'h2);
    wr(OFF_EP_BASE + 8'h04, 32'hC0);
    rd(OFF_EP_BASE + 8'h04, 32'h0);
    wr(OFF_EP_BASE, 32'h0);
    chk({31'h0, nak}, 32'h1);
    ep_sel <= 4'h2;
    wr(OFF_EP_BASE + 8'h08, 32'h1D);
    chk({27'h0, ep_ctrl}, 32'h19);
    wr(OFF_EP_BASE + 8'h08, 32'h0D);
    chk({27'h0, ep_ctrl}, 32'h1D);
    wr(OFF_EP_BASE + 8'h08, 32'h06);
    chk({28'h0, ep_ctrl.rx_allow, ep_ctrl.tx_allow, ep_ctrl.stalled, ep_ctrl.handshake}, 32'h6);
    wr(OFF_MODE, 32'h0);
  endtask : t_endpoints
  task automatic t_misc();
    int a;
    wr(OFF_PWM_CONTROL, 32'hFFFF_FFFF);
    rd(OFF_PWM_CONTROL, 32'h8300);
    chk({29'h0, pen, pcnt, pidle}, 32'h7);
    wr(OFF_PWM_CONTROL, 32'h0100);
    chk({29'h0, pen, pcnt, pidle}, 32'h2);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    over_req <= 1'b1;
    repeat (2) @(posedge clock);
    chk({31'h0, trunc}, 32'h1);
    over_req <= 1'b0;
    fire(8'h00, 8'h08);
    a = adv_cnt;
    wr(OFF_IRQ_FLAGS, 32'h08);
    repeat (3) @(posedge clock);
    chk(adv_cnt - a, 32'h1);
  endtask : t_misc
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  initial begin
    {nrst, cyc, stb, we, over_req, adr, dat, sel, ep_sel} = '0;
    {err_req, usb_req} = 16'h0000;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_usb_irq();
    t_errors(1'b0);
    t_errors(1'b1);
    t_summary();
    t_endpoints();
    t_misc();
    complete_run();
  end
endmodule : tb
